// ---- esf_front.v ----
// Purpose: Serial-bus slave front end of a byte-wide nonvolatile memory.
// Assumes: Bus lines sampled synchronously and far slower than i_ref_clk.
// Notes:   Written bytes leave through a 4-word FIFO; reads use i_rd_data.
//
// What this block does
// - Start is data falling while clock stays high.
// - Stop is data rising while clock high; it ends the exchange.
// - Start is watched always, except during the internal write cycle.
// - First byte: type 1010, chip select, direction; MSB first.
// - Select bits b3..b1 must equal the three strap inputs.
// - Floating straps read as zero, giving select value 000.
// - Write-protect high blocks writes to the whole array.
// - Floating write-protect reads low, so writes are allowed.
// - Write-protect high still acks select and address, nacks data.
// - Device acks in ninth slot after each byte it receives, except bad select, or data with write-protect high or FIFO full.
// - Read ending in nack and Stop returns device to standby.
// - Stop right after a data byte's ack slot starts the internal write cycle if a data byte was accepted.
// - Held in reset and standby while power-on reset asserts.
// - Reasserted power-on reset returns device to reset.
// - Address is two bytes, high byte first.
// - Array holds 8192 byte locations.
// - Device is slave only; master drives the clock.
// - Data line driven only low, open drain.
// - Data sampled on clock rise; master changes data while clock low.
// - Mismatching select byte: no ack, bus released, standby.
// - Direction bit one reads, zero writes.
// - Only Stop right after a data byte ack starts a write.
`include "esf_map.vh"

module esf_front #(
  parameter WRITE_CYCLES = `ESF_TW_CYC,
  parameter ADDR_W       = `ESF_ADDR_W,
  parameter FIFO_DEPTH   = `ESF_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire                  i_ref_clk,
  input  wire                  i_rstn,
  input  wire                  i_ce,
  // Serial bus pins
  input  wire                  i_scl,
  input  wire                  i_sda_in,
  output reg                   o_sda_out,
  output reg                   o_sda_oe,
  // Straps and protection
  input  wire                  i_chip_select_strap_0,
  input  wire                  i_chip_select_strap_1,
  input  wire                  i_chip_select_strap_2,
  input  wire                  i_write_protect_input,
  // Array read side
  output reg  [ADDR_W-1:0]     o_rd_addr,
  input  wire [7:0]            i_rd_data,
  // Array write side
  output wire                  o_wr_valid,
  output wire [ADDR_W+7:0]     o_wr_word,
  input  wire                  i_wr_ready,
  // Status
  output reg                   o_busy,
  output reg                   o_standby
);

  // One-hot states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RX   = 6'h02;
  localparam [5:0] S_ACK  = 6'h04;
  localparam [5:0] S_TX   = 6'h08;
  localparam [5:0] S_MACK = 6'h10;
  localparam [5:0] S_WCYC = 6'h20;

  localparam [31:0] WCYC_LAST = WRITE_CYCLES - 1;

  reg  [5:0]        state_ff;
  reg  [5:0]        nxt_state;
  reg               scl_ff;
  reg               sda_ff;
  reg               scl_old_ff;
  reg               sda_old_ff;
  reg  [3:0]        cnt_ff;
  reg  [7:0]        shift_ff;
  reg  [1:0]        phase_ff;
  reg               read_ff;
  reg               ack_ff;
  reg               wr_any_ff;
  reg               after_dack_ff;
  reg               mack_ff;
  reg  [15:0]       addr_ff;
  reg  [31:0]       wcnt_ff;
  reg               push_ff;
  reg  [ADDR_W+7:0] push_word_ff;
  wire              scl_rise;
  wire              scl_fall;
  wire              start_seen;
  wire              stop_seen;
  wire              fifo_in_ready;
  wire [7:0]        byte_now;
  wire [2:0]        straps;

  // Straps in select bit order; pads pull floating straps low
  assign straps = {i_chip_select_strap_2, i_chip_select_strap_1, i_chip_select_strap_0};

  // Select byte matches type pattern and straps
  function sel_match;
    input [7:0] b;
    input [2:0] s;
    begin
      sel_match = (b[`ESF_TYPE_MSB:`ESF_TYPE_LSB] == `ESF_TYPE_ARRAY) &&
                  (b[`ESF_CS_MSB:`ESF_CS_LSB] == s);
    end
  endfunction

  // Bus line sampling; clock samples reset low so a half-seen Start is not taken
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_ff     <= 1'b0;
      sda_ff     <= 1'b1;
      scl_old_ff <= 1'b0;
      sda_old_ff <= 1'b1;
    end else if (i_ce) begin
      scl_ff     <= i_scl;
      sda_ff     <= i_sda_in;
      scl_old_ff <= scl_ff;
      sda_old_ff <= sda_ff;
    end
  end

  // Edge and condition decode
  assign scl_rise   = scl_ff && !scl_old_ff;
  assign scl_fall   = !scl_ff && scl_old_ff;
  assign start_seen = scl_ff && scl_old_ff && sda_old_ff && !sda_ff;
  assign stop_seen  = scl_ff && scl_old_ff && !sda_old_ff && sda_ff;
  assign byte_now   = {shift_ff[6:0], sda_ff};

  // Next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (start_seen) begin
          nxt_state = S_RX;
        end
      end
      S_WCYC: begin
        if (wcnt_ff == WCYC_LAST) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        if (start_seen) begin
          nxt_state = S_RX;
        end else if (stop_seen) begin
          nxt_state = (after_dack_ff && wr_any_ff) ? S_WCYC : S_IDLE;
        end else if (scl_fall) begin
          case (state_ff)
            S_RX: begin
              if (cnt_ff == `ESF_BITS) begin
                nxt_state = S_ACK;
              end
            end
            S_ACK: begin
              if (phase_ff == `ESF_PH_SEL && !ack_ff) begin
                nxt_state = S_IDLE;
              end else if (phase_ff == `ESF_PH_SEL && read_ff) begin
                nxt_state = S_TX;
              end else begin
                nxt_state = S_RX;
              end
            end
            S_TX: begin
              if (cnt_ff == `ESF_BITS) begin
                nxt_state = S_MACK;
              end
            end
            S_MACK: begin
              nxt_state = mack_ff ? S_TX : S_IDLE;
            end
            default: begin
              nxt_state = S_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // State register; reset holds standby
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= S_IDLE;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // Bit shifting, byte phases and data line drive
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff        <= 4'h0;
      shift_ff      <= 8'h00;
      phase_ff      <= `ESF_PH_SEL;
      read_ff       <= 1'b0;
      ack_ff        <= 1'b0;
      wr_any_ff     <= 1'b0;
      after_dack_ff <= 1'b0;
      mack_ff       <= 1'b0;
      addr_ff       <= 16'h0000;
      o_sda_out     <= 1'b0;
      o_sda_oe      <= 1'b0;
      push_ff       <= 1'b0;
      push_word_ff  <= {(ADDR_W+8){1'b0}};
    end else if (i_ce) begin
      push_ff   <= 1'b0;
      o_sda_out <= 1'b0;
      if (state_ff == S_WCYC) begin
        o_sda_oe <= 1'b0;
      end else if (start_seen) begin
        cnt_ff        <= 4'h0;
        phase_ff      <= `ESF_PH_SEL;
        wr_any_ff     <= 1'b0;
        after_dack_ff <= 1'b0;
        o_sda_oe      <= 1'b0;
      end else if (stop_seen) begin
        o_sda_oe      <= 1'b0;
        after_dack_ff <= 1'b0;
        wr_any_ff     <= 1'b0;
      end else if (state_ff != S_IDLE) begin
        // Sample on clock rise
        if (scl_rise) begin
          if (state_ff == S_RX && cnt_ff != `ESF_BITS) begin
            shift_ff <= byte_now;
            cnt_ff   <= cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              case (phase_ff)
                `ESF_PH_SEL: begin
                  ack_ff  <= sel_match(byte_now, straps);
                  read_ff <= (byte_now[`ESF_RW_BIT] == `ESF_RW_READ);
                end
                `ESF_PH_DATA: begin
                  ack_ff <= !i_write_protect_input && fifo_in_ready;
                end
                default: begin
                  ack_ff <= 1'b1;
                end
              endcase
            end
          end
          if (state_ff == S_MACK) begin
            mack_ff <= !sda_ff;
          end
        end
        // Drive on clock fall
        if (scl_fall) begin
          after_dack_ff <= 1'b0;
          case (state_ff)
            S_RX: begin
              if (cnt_ff == `ESF_BITS) begin
                o_sda_oe <= ack_ff;
              end
            end
            S_ACK: begin
              o_sda_oe <= 1'b0;
              cnt_ff   <= 4'h0;
              case (phase_ff)
                `ESF_PH_SEL: begin
                  if (ack_ff) begin
                    phase_ff <= `ESF_PH_ADDRH;
                    if (read_ff) begin
                      shift_ff <= {i_rd_data[6:0], 1'b0};
                      o_sda_oe <= !i_rd_data[7];
                      cnt_ff   <= 4'h1;
                    end
                  end
                end
                `ESF_PH_ADDRH: begin
                  addr_ff[15:8] <= shift_ff;
                  phase_ff      <= `ESF_PH_ADDRL;
                end
                `ESF_PH_ADDRL: begin
                  addr_ff[7:0] <= shift_ff;
                  phase_ff     <= `ESF_PH_DATA;
                end
                default: begin
                  after_dack_ff <= 1'b1;
                  if (ack_ff) begin
                    push_ff      <= 1'b1;
                    push_word_ff <= {addr_ff[ADDR_W-1:0], shift_ff};
                    addr_ff      <= addr_ff + 16'h0001;
                    wr_any_ff    <= 1'b1;
                  end
                end
              endcase
            end
            S_TX: begin
              if (cnt_ff == `ESF_BITS) begin
                o_sda_oe <= 1'b0;
                addr_ff  <= addr_ff + 16'h0001;
              end else begin
                o_sda_oe <= !shift_ff[7];
                shift_ff <= {shift_ff[6:0], 1'b0};
                cnt_ff   <= cnt_ff + 4'h1;
              end
            end
            S_MACK: begin
              if (mack_ff) begin
                shift_ff <= {i_rd_data[6:0], 1'b0};
                o_sda_oe <= !i_rd_data[7];
                cnt_ff   <= 4'h1;
              end else begin
                o_sda_oe <= 1'b0;
              end
            end
            default: begin
              o_sda_oe <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Write cycle timer
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wcnt_ff <= 32'h00000000;
    end else if (i_ce) begin
      if (state_ff == S_WCYC) begin
        wcnt_ff <= wcnt_ff + 32'h00000001;
      end else begin
        wcnt_ff <= 32'h00000000;
      end
    end
  end

  // Status and read address outputs
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy    <= 1'b0;
      o_standby <= 1'b1;
      o_rd_addr <= {ADDR_W{1'b0}};
    end else if (i_ce) begin
      o_busy    <= (nxt_state == S_WCYC);
      o_standby <= (nxt_state == S_IDLE);
      o_rd_addr <= addr_ff[ADDR_W-1:0];
    end
  end

  // Written bytes wait here for the array port
  esf_fifo #(
    .WIDTH (ADDR_W + 8),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_ce        (i_ce),
    .i_in_valid  (push_ff),
    .i_in_data   (push_word_ff),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_wr_valid),
    .o_out_data  (o_wr_word),
    .i_out_ready (i_wr_ready),
    .o_full      (),
    .o_empty     ()
  );

endmodule

// ---- esf_map.vh ----
// Purpose: Constants of the serial EEPROM slave front end.
// Assumes: Included by every design file of the block.
// Notes:   Timing counts are derived from the 50 MHz reference clock.
`ifndef ESF_MAP_VH
`define ESF_MAP_VH

// Select byte layout
`define ESF_TYPE_MSB   7
`define ESF_TYPE_LSB   4
`define ESF_TYPE_ARRAY 4'ha
`define ESF_CS_MSB     3
`define ESF_CS_LSB     1
`define ESF_RW_BIT     0
`define ESF_RW_READ    1'b1

// Byte phases of a write command
`define ESF_PH_SEL     2'h0
`define ESF_PH_ADDRH   2'h1
`define ESF_PH_ADDRL   2'h2
`define ESF_PH_DATA    2'h3

// Bits per byte on the bus
`define ESF_BITS       4'h8

// Array geometry
`define ESF_ADDR_W     13
`define ESF_DATA_W     8

// Write time and clock rate
`define ESF_TW_US      5000
`define ESF_CLK_MHZ    50
`define ESF_TW_CYC     (`ESF_TW_US * `ESF_CLK_MHZ)

// Buffer depth
`define ESF_FIFO_DEPTH 4

`endif

// ---- esf_fifo.v ----
// Purpose: Small FIFO between byte capture and the array write port.
// Assumes: Single clock; push only while o_in_ready is high.
// Notes:   Read data leave through an output register.
`include "esf_map.vh"

module esf_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = `ESF_FIFO_DEPTH,
  parameter AW    = 2
) (
  // Clock, reset, enable
  input  wire             i_ref_clk,
  input  wire             i_rstn,
  input  wire             i_ce,
  // Fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // Drain side
  output reg              o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready,
  // Status
  output wire             o_full,
  output wire             o_empty
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wptr_ff;
  reg [AW-1:0]    rptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  // Storage occupancy and handshakes
  assign o_full     = ((count_ff + {{AW{1'b0}}, o_out_valid}) == DEPTH[AW:0]); // Output register holds a word too
  assign o_empty    = (count_ff == {(AW+1){1'b0}}) && !o_out_valid;
  assign o_in_ready = !o_full;
  assign push       = i_in_valid && !o_full;
  assign pop        = (count_ff != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);

  // Storage write
  always @(posedge i_ref_clk) begin
    if (i_ce && push) begin
      mem_ff[wptr_ff] <= i_in_data;
    end
  end

  // Pointers, count and output register
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_ff     <= {AW{1'b0}};
      rptr_ff     <= {AW{1'b0}};
      count_ff    <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      if (push) begin
        wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff    <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
        o_out_data <= mem_ff[rptr_ff];
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
      if (pop) begin
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end

endmodule

// ---- esf_front_monitor.sv ----
// Purpose: Port checks for bus answers, write cycle and drain side.
// Assumes: One clock domain, async active-low reset.
// Notes:   Attached to the front end by bind at the foot.
module esf_front_monitor #(
  parameter WRITE_CYCLES = 20,
  parameter ADDR_W       = 13
) (
  // Clock and reset
  input logic              i_ref_clk,
  input logic              i_rstn,
  // Serial bus
  input logic              i_scl,
  input logic              i_sda_in,
  input logic              o_sda_out,
  input logic              o_sda_oe,
  // Drain side and status
  input logic              o_wr_valid,
  input logic [ADDR_W+7:0] o_wr_word,
  input logic              i_wr_ready,
  input logic              o_busy,
  input logic              o_standby
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // Length of the running write cycle
  assign nxt_busy_cnt = o_busy ? busy_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) busy_cnt_ff <= 32'h0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end

  drive_only_low_a: assert property (o_sda_out == 1'h0)
    else $error("data output not low");
  quiet_when_busy_a: assert property (o_busy |-> !o_sda_oe)
    else $error("line pulled in write cycle");
  busy_not_idle_a: assert property (o_busy |-> !o_standby)
    else $error("standby in write cycle");
  busy_after_stop_a: assert property ($rose(o_busy) |-> i_scl && i_sda_in)
    else $error("write cycle without stop");
  busy_length_a: assert property ($fell(o_busy) |-> busy_cnt_ff == WRITE_CYCLES)
    else $error("write cycle length wrong");
  ack_on_low_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("pull started with clock high");
  ack_stands_a: assert property ($rose(o_sda_oe) |=> o_sda_oe [*4])
    else $error("pull too short");
  release_on_low_a: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("release with clock high");
  idle_released_a: assert property (o_standby |-> !o_sda_oe)
    else $error("line pulled in standby");
  word_held_a: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_word))
    else $error("word dropped before taken");
endmodule

bind esf_front esf_front_monitor #(.WRITE_CYCLES(WRITE_CYCLES), .ADDR_W(ADDR_W)) esf_front_monitor_inst (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda_in(i_sda_in),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
  .o_wr_word(o_wr_word), .i_wr_ready(i_wr_ready), .o_busy(o_busy), .o_standby(o_standby));

// ---- esf_mst.sv ----
// Purpose: Bus master model that clocks and frames the serial bus.
// Assumes: Data line open drain with pull-up; clock push-pull.
// Notes:   Six-cycle clock halves; clock rests high between frames.
module esf_mst (
  input  logic i_ref_clk,
  input  logic i_dev_oe,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pull_low = 1'h0;

  // Clock rests high outside frames
  initial o_scl = 1'h1;
  // Wired line: either party pulls low, else pull-up
  assign o_sda = !(pull_low || i_dev_oe);

  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // One bit slot; data moves only while clock low
  task automatic slot(input logic b, output logic seen);
    o_scl = 1'h0;
    tick(3);
    pull_low = !b;
    tick(3);
    o_scl = 1'h1;
    tick(5);
    seen = o_sda;
    tick(1);
  endtask

  task automatic start();
    o_scl = 1'h0;
    tick(3);
    pull_low = 1'h0;
    tick(3);
    o_scl = 1'h1;
    tick(6);
    pull_low = 1'h1;
    tick(6);
  endtask

  task automatic stop();
    o_scl = 1'h0;
    tick(3);
    pull_low = 1'h1;
    tick(3);
    o_scl = 1'h1;
    tick(6);
    pull_low = 1'h0;
    tick(6);
  endtask

  // Byte out, then release for the answer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'h1, s);
    ack = !s;
  endtask

  // Byte in, then own answer
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'h1, s);
      d[i] = s;
    end
    slot(!ack, s);
  endtask
endmodule

// ---- esf_front_tb.sv ----
// Purpose: Self-checking bench for the serial memory front end.
// Assumes: Master model on the bus; array read side modelled here.
// Notes:   Write cycle shortened to 20 clocks.
module esf_front_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WCYC = 20;
  typedef struct packed {
    logic [2:0]  strap;
    logic [7:0]  sel;
    logic        wp;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        sel_ack;
    logic        data_ack;
  } esf_row_t;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [2:0]  strap = 3'h0;
  logic        wp = 1'h0;
  logic        wr_ready = 1'h0;
  logic        ack;
  logic [7:0]  rd;
  wire         scl;
  wire         sda;
  wire         sda_oe;
  wire [12:0]  rd_addr;
  wire         wr_valid;
  wire [20:0]  wr_word;
  wire         busy;
  wire         standby;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  esf_row_t    rows [6];

  always #10 clk = ~clk;

  esf_front #(.WRITE_CYCLES(WCYC)) esf_front_inst (
    .i_ref_clk(clk), .i_rstn(rstn), .i_ce(1'h1), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(), .o_sda_oe(sda_oe), .i_chip_select_strap_0(strap[0]),
    .i_chip_select_strap_1(strap[1]), .i_chip_select_strap_2(strap[2]),
    .i_write_protect_input(wp), .o_rd_addr(rd_addr), .i_rd_data(rd_addr[7:0] ^ 8'h3c),
    .o_wr_valid(wr_valid), .o_wr_word(wr_word), .i_wr_ready(wr_ready),
    .o_busy(busy), .o_standby(standby));

  esf_mst esf_mst_inst (.i_ref_clk(clk), .i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input string name, input logic [20:0] seen, input logic [20:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Take one word from the drain side
  task automatic drain();
    wr_ready = 1'h1;
    tick(1);
    wr_ready = 1'h0;
    tick(2);
  endtask

  // Start, write select and both address bytes
  task automatic head(input logic [15:0] a);
    esf_mst_inst.start();
    esf_mst_inst.send_byte(8'ha0, ack);
    check("sel_ack", ack, 1'h1);
    esf_mst_inst.send_byte(a[15:8], ack);
    esf_mst_inst.send_byte(a[7:0], ack);
    check("addr_ack", ack, 1'h1);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    rows = '{
      {3'h0, 8'ha0, 1'h0, 16'h0123, 8'h5a, 1'h1, 1'h1},
      {3'h5, 8'haa, 1'h0, 16'hffff, 8'ha5, 1'h1, 1'h1},
      {3'h3, 8'ha6, 1'h0, 16'h0040, 8'h3c, 1'h1, 1'h1},
      {3'h5, 8'ha6, 1'h0, 16'h0000, 8'h00, 1'h0, 1'h0},
      {3'h0, 8'h20, 1'h0, 16'h0000, 8'h00, 1'h0, 1'h0},
      {3'h0, 8'ha0, 1'h1, 16'h0200, 8'h77, 1'h1, 1'h0}};
    tick(10);
    check("standby", standby, 1'h1);
    check("oe", sda_oe, 1'h0);
    check("busy", busy, 1'h0);
    check("wr_valid", wr_valid, 1'h0);
    rstn = 1'h1;
    tick(2);
    // Select, strap and protect table
    for (int r = 0; r < 6; r++) begin
      strap = rows[r].strap;
      wp = rows[r].wp;
      esf_mst_inst.start();
      esf_mst_inst.send_byte(rows[r].sel, ack);
      check("sel_ack", ack, rows[r].sel_ack);
      if (rows[r].sel_ack) begin
        esf_mst_inst.send_byte(rows[r].addr[15:8], ack);
        check("addrh_ack", ack, 1'h1);
        esf_mst_inst.send_byte(rows[r].addr[7:0], ack);
        check("addrl_ack", ack, 1'h1);
        esf_mst_inst.send_byte(rows[r].data, ack);
        check("data_ack", ack, rows[r].data_ack);
      end
      esf_mst_inst.stop();
      check("busy", busy, rows[r].data_ack);
      check("wr_valid", wr_valid, rows[r].data_ack);
      if (rows[r].data_ack) check("wr_word", wr_word, {rows[r].addr[12:0], rows[r].data});
      drain();
      tick(WCYC);
      check("standby", standby, 1'h1);
    end
    // Start during the write cycle is ignored
    strap = 3'h0;
    wp = 1'h0;
    head(16'h0010);
    esf_mst_inst.send_byte(8'h11, ack);
    esf_mst_inst.stop();
    esf_mst_inst.start();
    esf_mst_inst.send_byte(8'ha0, ack);
    check("busy_sel_ack", ack, 1'h0);
    esf_mst_inst.stop();
    check("wr_word", wr_word, {13'h0010, 8'h11});
    drain();
    // Stop after an address byte starts nothing
    head(16'h0020);
    esf_mst_inst.stop();
    check("busy", busy, 1'h0);
    // Address set, then read two bytes
    head(16'h0007);
    esf_mst_inst.start();
    esf_mst_inst.send_byte(8'ha1, ack);
    check("rd_sel_ack", ack, 1'h1);
    esf_mst_inst.recv_byte(1'h1, rd);
    check("rd_byte0", rd, 8'h07 ^ 8'h3c);
    esf_mst_inst.recv_byte(1'h0, rd);
    check("rd_byte1", rd, 8'h08 ^ 8'h3c);
    esf_mst_inst.stop();
    check("standby", standby, 1'h1);
    // Fill the buffer with the drain stalled
    head(16'h0100);
    for (int i = 0; i < 5; i++) begin
      esf_mst_inst.send_byte(8'h10 + i[7:0], ack);
      check("fifo_ack", ack, i < 4);
    end
    esf_mst_inst.stop();
    check("busy", busy, 1'h1);
    for (int i = 0; i < 4; i++) begin
      check("fifo_word", wr_word, {13'h0100 + i[12:0], 8'h10 + i[7:0]});
      drain();
    end
    check("wr_valid", wr_valid, 1'h0);
    tick(WCYC);
    // Reset inside a frame; no answer without a new start
    esf_mst_inst.start();
    rstn = 1'h0;
    tick(3);
    check("oe", sda_oe, 1'h0);
    check("standby", standby, 1'h1);
    rstn = 1'h1;
    tick(2);
    esf_mst_inst.send_byte(8'ha0, ack);
    check("no_start_ack", ack, 1'h0);
    esf_mst_inst.stop();
    conclude();
  end
endmodule
